// >>> core/hfdu_pkg.sv
// Functional notes
// [R1] One serial receive input line and one separate serial transmit output.
// [R2] Rates 300 to 115200 bit/s selectable; divisors assume 10 MHz base (the code divides the 200 MHz aclk instead).
// [R3] One-direction transmit sends frames back to back, no idle gap.
// [R4] Receive and transmit share one configured bit rate.
// [R5] Simultaneous operation may slow transmit at the highest two rates.
// [R6] All rates work full duplex; only added transmit gaps allowed.
// [R7] At a 6.5536 MHz base the rate is limited to 19200.
// [R8] Frame: one start bit, eight data bits, one or two stop bits.
// [R9] One request moves up to 255 bytes each direction independently.
// [R10] Bad stop bit does not halt reception; receiver resynchronises.
// [R11] Bad stop bit sets a sticky framing-error status bit.
// [R12] Arming reception returns at once; completion seen by polling.
// [R13] Disabling the receive enable pauses reception; enabling resumes it.
// [R14] Software may abort a reception in progress.
// [R15] Transmit request completes once the last byte is in the shifter.
// [R16] Armed reception keeps capturing while transmission runs.
// [R17] Software should service received bytes promptly at high rates.
// [R18] A valid stop bit is level 1; otherwise it is an error.
// [R19] Line idles high, start bit low, data least significant bit first.
// [R20] Receiver samples bit centres timed from the start-bit falling edge.
package hfdu_pkg;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_TXDATA  = 8'h08;
	localparam logic [7:0] ADDR_RXDATA  = 8'h0c;
	localparam logic [7:0] ADDR_TXCOUNT = 8'h10;
	localparam logic [7:0] ADDR_RXCOUNT = 8'h14;
	// Control fields
	localparam int CTRL_RATE_LSB = 0;
	localparam int CTRL_TWO_STOP = 4;
	localparam int CTRL_RX_IE    = 5;
	localparam int CTRL_RX_ABORT = 6;
	localparam int CTRL_SLOW_CLK = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0025;
	// Status fields
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_TX_READY = 1;
	localparam int ST_RX_DONE  = 2;
	localparam int ST_TX_DONE  = 3;
	localparam int ST_FRAME    = 4;
	localparam int ST_RX_BUSY  = 5;
	localparam int ST_TX_BUSY  = 6;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int unsigned CLK_HZ  = 200_000_000;
	localparam int unsigned BASE_HZ = 10_000_000;
	localparam int unsigned SLOW_HZ = 6_553_600;
	localparam logic [3:0] RATE_MAX      = 4'd9;
	localparam logic [3:0] RATE_SLOW_MAX = 4'd6;
	localparam int DIV_W = 20;
	localparam int CNT_W = 8;
	typedef enum logic [3:0] {
		HFDU_IDLE  = 4'b0001,
		HFDU_START = 4'b0010,
		HFDU_DATA  = 4'b0100,
		HFDU_STOP  = 4'b1000
	} hfdu_state_t;
	function automatic int unsigned rate_bps(input logic [3:0] sel);
		case (sel)
			4'd0: rate_bps = 300;
			4'd1: rate_bps = 600;
			4'd2: rate_bps = 1200;
			4'd3: rate_bps = 2400;
			4'd4: rate_bps = 4800;
			4'd5: rate_bps = 9600;
			4'd6: rate_bps = 19200;
			4'd7: rate_bps = 38400;
			4'd8: rate_bps = 57600;
			default: rate_bps = 115200;
		endcase
	endfunction
	// Cycles of aclk per bit
	function automatic logic [DIV_W-1:0] bit_cycles(input logic [3:0] sel);
		bit_cycles = DIV_W'(CLK_HZ / rate_bps(sel));
	endfunction
endpackage

// >>> core/hfdu_rate_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hfdu_rate_if;
	logic [19:0] bit_len;
	logic        two_stop;
	modport src (output bit_len, output two_stop);
	modport dst (input bit_len, input two_stop);
endinterface
`default_nettype wire

// >>> core/hfdu_tx.sv
`timescale 1ns/1ps
`default_nettype none
module hfdu_tx (
	input  wire logic       aclk,     // Clock
	input  wire logic       aresetn,  // Sync reset
	hfdu_rate_if.dst        rate,     // Shared rate
	input  wire logic       ld_valid, // Byte offered
	input  wire logic [7:0] ld_data,  // Byte
	output logic            ld_ready, // Shifter can take byte
	output logic            txd_ff    // Serial line
);
	hfdu_pkg::hfdu_state_t state_ff;
	logic [19:0]           cnt_ff;
	logic [2:0]            bit_ff;
	logic [7:0]            sh_ff;
	logic                  stop2_ff;
	logic                  bit_end;

	assign bit_end  = (cnt_ff == rate.bit_len - 20'd1);
	// Load in idle or in the last stop bit cycle: back to back frames
	assign ld_ready = (state_ff == hfdu_pkg::HFDU_IDLE) ||
		((state_ff == hfdu_pkg::HFDU_STOP) && bit_end && !stop2_ff); // [R3]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= hfdu_pkg::HFDU_IDLE;
			cnt_ff   <= '0;
			bit_ff   <= '0;
			sh_ff    <= '0;
			stop2_ff <= 1'b0;
			txd_ff   <= 1'b1;
		end else begin
			cnt_ff <= bit_end ? 20'd0 : cnt_ff + 20'd1;
			if (ld_valid && ld_ready) begin
				state_ff <= hfdu_pkg::HFDU_START;
				sh_ff    <= ld_data;
				cnt_ff   <= '0;
				txd_ff   <= 1'b0; // [R19]
			end else begin
				case (state_ff)
					hfdu_pkg::HFDU_IDLE: begin
						cnt_ff <= '0;
						txd_ff <= 1'b1;
					end
					hfdu_pkg::HFDU_START: if (bit_end) begin
						state_ff <= hfdu_pkg::HFDU_DATA;
						bit_ff   <= '0;
						txd_ff   <= sh_ff[0]; // [R19]
					end
					hfdu_pkg::HFDU_DATA: if (bit_end) begin
						sh_ff  <= {1'b0, sh_ff[7:1]};
						bit_ff <= bit_ff + 3'd1;
						if (bit_ff == 3'd7) begin
							state_ff <= hfdu_pkg::HFDU_STOP;
							stop2_ff <= rate.two_stop; // [R8]
							txd_ff   <= 1'b1;
						end else begin
							txd_ff <= sh_ff[1];
						end
					end
					hfdu_pkg::HFDU_STOP: if (bit_end) begin
						if (stop2_ff)
							stop2_ff <= 1'b0;
						else
							state_ff <= hfdu_pkg::HFDU_IDLE;
					end
					default: state_ff <= hfdu_pkg::HFDU_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/hfdu_top.sv
`timescale 1ns/1ps
`default_nettype none
module hfdu_top (
	input  wire logic        aclk,                // 200 MHz clock
	input  wire logic        aresetn,             // Sync reset, low
	input  wire logic [7:0]  s_axi_awaddr,        // Write address
	input  wire logic        s_axi_awvalid,       // Write address valid
	output logic             s_axi_awready,       // Write address ready
	input  wire logic [31:0] s_axi_wdata,         // Write data
	input  wire logic [3:0]  s_axi_wstrb,         // Byte enables
	input  wire logic        s_axi_wvalid,        // Write data valid
	output logic             s_axi_wready,        // Write data ready
	output logic [1:0]       s_axi_bresp,         // Write response
	output logic             s_axi_bvalid,        // Write response valid
	input  wire logic        s_axi_bready,        // Write response ready
	input  wire logic [7:0]  s_axi_araddr,        // Read address
	input  wire logic        s_axi_arvalid,       // Read address valid
	output logic             s_axi_arready,       // Read address ready
	output logic [31:0]      s_axi_rdata,         // Read data
	output logic [1:0]       s_axi_rresp,         // Read response
	output logic             s_axi_rvalid,        // Read data valid
	input  wire logic        s_axi_rready,        // Read data ready
	input  wire logic        serial_receive_pin,  // Serial in
	output logic             serial_transmit_pin  // Serial out
);
	// ------------------------------------------------------------
	// Registers and shared rate
	// ------------------------------------------------------------
	logic [31:0] ctrl_ff;
	logic [7:0]  tx_hold_ff;
	logic        tx_full_ff;
	logic [7:0]  tx_left_ff;
	logic        tx_done_ff;
	logic [7:0]  rx_left_ff;
	logic [7:0]  rx_data_ff;
	logic        rx_avail_ff;
	logic        rx_done_ff;
	logic        frame_err_ff;
	logic        aw_ok_ff;
	logic        w_ok_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        txd;
	logic        ld_ready;
	logic        do_write;
	logic        do_read;
	logic [3:0]  rate_sel;
	logic        rx_byte;
	logic        rx_ferr;
	logic        rx_ie;
	hfdu_rate_if rate ();

	// Limit rate to what the base clock supports
	assign rate_sel = ctrl_ff[hfdu_pkg::CTRL_SLOW_CLK] ?
		((ctrl_ff[3:0] > hfdu_pkg::RATE_SLOW_MAX) ?
			hfdu_pkg::RATE_SLOW_MAX : ctrl_ff[3:0]) : // [R7]
		((ctrl_ff[3:0] > hfdu_pkg::RATE_MAX) ?
			hfdu_pkg::RATE_MAX : ctrl_ff[3:0]); // [R2]
	// One divisor feeds both directions
	assign rate.bit_len  = hfdu_pkg::bit_cycles(rate_sel); // [R4]
	assign rate.two_stop = ctrl_ff[hfdu_pkg::CTRL_TWO_STOP];
	assign rx_ie         = ctrl_ff[hfdu_pkg::CTRL_RX_IE];

	// ------------------------------------------------------------
	// AXI4-Lite write
	// ------------------------------------------------------------
	assign do_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff      <= 1'b0;
			w_ok_ff       <= 1'b0;
			aw_addr_ff    <= '0;
			w_data_ff     <= '0;
			w_strb_ff     <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= hfdu_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff   <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff   <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_ok_ff     <= 1'b0;
				w_ok_ff      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_ff)
					hfdu_pkg::ADDR_CTRL, hfdu_pkg::ADDR_STATUS,
					hfdu_pkg::ADDR_TXDATA, hfdu_pkg::ADDR_TXCOUNT,
					hfdu_pkg::ADDR_RXCOUNT:
						s_axi_bresp <= hfdu_pkg::RESP_OKAY;
					default: s_axi_bresp <= hfdu_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= hfdu_pkg::CTRL_RESET;
		end else begin
			if (do_write && aw_addr_ff == hfdu_pkg::ADDR_CTRL &&
			    w_strb_ff[0])
				ctrl_ff[7:0] <= w_data_ff[7:0];
			// Abort bit is self clearing
			if (ctrl_ff[hfdu_pkg::CTRL_RX_ABORT])
				ctrl_ff[hfdu_pkg::CTRL_RX_ABORT] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold_ff <= '0;
			tx_full_ff <= 1'b0;
			tx_left_ff <= '0;
			tx_done_ff <= 1'b0;
		end else begin
			if (do_write && aw_addr_ff == hfdu_pkg::ADDR_TXCOUNT &&
			    w_strb_ff[0]) begin
				tx_left_ff <= w_data_ff[7:0]; // [R9]
				tx_done_ff <= 1'b0;
			end
			if (do_write && aw_addr_ff == hfdu_pkg::ADDR_TXDATA &&
			    w_strb_ff[0] && !tx_full_ff && tx_left_ff != 8'd0) begin
				tx_hold_ff <= w_data_ff[7:0];
				tx_full_ff <= 1'b1;
			end
			if (tx_full_ff && ld_ready) begin // [R5] [R6]
				tx_full_ff <= 1'b0;
				tx_left_ff <= tx_left_ff - 8'd1;
				// Done once the final byte sits in the shifter
				if (tx_left_ff == 8'd1)
					tx_done_ff <= 1'b1; // [R15]
			end
		end
	end

	hfdu_tx u_tx (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.rate     (rate.dst),
		.ld_valid (tx_full_ff),
		.ld_data  (tx_hold_ff),
		.ld_ready (ld_ready),
		.txd_ff   (txd)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			serial_transmit_pin <= 1'b1;
		else
			serial_transmit_pin <= txd; // [R1]
	end

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------
	hfdu_pkg::hfdu_state_t rx_state_ff;
	logic [19:0] rx_cnt_ff;
	logic [2:0]  rx_bit_ff;
	logic [7:0]  rx_sh_ff;
	logic        rxd_meta_ff;
	logic        rxd_ff;
	logic        rx_run;
	logic        rx_mid;

	// Paused when enable is low, counter frozen
	assign rx_run = rx_ie && rx_left_ff != 8'd0 && !rx_done_ff; // [R13]
	assign rx_mid = rx_cnt_ff == (rx_state_ff == hfdu_pkg::HFDU_START ?
		{1'b0, rate.bit_len[19:1]} : rate.bit_len) - 20'd1; // [R20]
	assign rx_byte = rx_run && rx_mid &&
		rx_state_ff == hfdu_pkg::HFDU_STOP;
	assign rx_ferr = rx_byte && !rxd_ff; // [R18]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_meta_ff <= 1'b1;
			rxd_ff      <= 1'b1;
		end else begin
			rxd_meta_ff <= serial_receive_pin;
			rxd_ff      <= rxd_meta_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ctrl_ff[hfdu_pkg::CTRL_RX_ABORT]) begin
			rx_state_ff <= hfdu_pkg::HFDU_IDLE; // [R14]
			rx_cnt_ff   <= '0;
			rx_bit_ff   <= '0;
			rx_sh_ff    <= '0;
		end else if (rx_run) begin // [R16]
			rx_cnt_ff <= rx_mid ? 20'd0 : rx_cnt_ff + 20'd1;
			case (rx_state_ff)
				hfdu_pkg::HFDU_IDLE: begin
					rx_cnt_ff <= '0;
					if (!rxd_ff)
						rx_state_ff <= hfdu_pkg::HFDU_START; // [R19]
				end
				hfdu_pkg::HFDU_START: if (rx_mid) begin
					// False start returns to idle
					rx_state_ff <= rxd_ff ? hfdu_pkg::HFDU_IDLE :
						hfdu_pkg::HFDU_DATA;
					rx_bit_ff <= '0;
				end
				hfdu_pkg::HFDU_DATA: if (rx_mid) begin
					rx_sh_ff  <= {rxd_ff, rx_sh_ff[7:1]}; // [R19]
					rx_bit_ff <= rx_bit_ff + 3'd1;
					if (rx_bit_ff == 3'd7)
						rx_state_ff <= hfdu_pkg::HFDU_STOP; // [R8]
				end
				hfdu_pkg::HFDU_STOP: if (rx_mid)
					// Back to hunting even on a bad stop bit
					rx_state_ff <= hfdu_pkg::HFDU_IDLE; // [R10]
				default: rx_state_ff <= hfdu_pkg::HFDU_IDLE;
			endcase
		end
	end

	assign do_read = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_left_ff   <= '0;
			rx_done_ff   <= 1'b0;
			rx_data_ff   <= '0;
			rx_avail_ff  <= 1'b0;
			frame_err_ff <= 1'b0;
		end else begin
			if (do_read && s_axi_araddr == hfdu_pkg::ADDR_RXDATA)
				rx_avail_ff <= 1'b0;
			if (do_write && aw_addr_ff == hfdu_pkg::ADDR_STATUS &&
			    w_data_ff[hfdu_pkg::ST_FRAME] && w_strb_ff[0])
				frame_err_ff <= 1'b0;
			if (do_write && aw_addr_ff == hfdu_pkg::ADDR_RXCOUNT &&
			    w_strb_ff[0]) begin
				rx_left_ff <= w_data_ff[7:0]; // [R12]
				rx_done_ff <= 1'b0;
			end
			if (ctrl_ff[hfdu_pkg::CTRL_RX_ABORT]) begin
				rx_left_ff <= '0; // [R14]
				rx_done_ff <= 1'b1;
			end else if (rx_byte) begin
				rx_data_ff  <= rx_sh_ff;
				rx_avail_ff <= 1'b1;
				rx_left_ff  <= rx_left_ff - 8'd1; // [R9]
				if (rx_left_ff == 8'd1)
					rx_done_ff <= 1'b1;
			end
			// Set wins over the clear
			if (rx_ferr)
				frame_err_ff <= 1'b1; // [R11]
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= hfdu_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= hfdu_pkg::RESP_OKAY;
				s_axi_rdata  <= '0;
				case (s_axi_araddr)
					hfdu_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_ff;
					hfdu_pkg::ADDR_STATUS: begin
						s_axi_rdata[hfdu_pkg::ST_RX_AVAIL] <= rx_avail_ff;
						s_axi_rdata[hfdu_pkg::ST_TX_READY] <= !tx_full_ff;
						s_axi_rdata[hfdu_pkg::ST_RX_DONE]  <= rx_done_ff;
						s_axi_rdata[hfdu_pkg::ST_TX_DONE]  <= tx_done_ff;
						s_axi_rdata[hfdu_pkg::ST_FRAME]    <= frame_err_ff;
						s_axi_rdata[hfdu_pkg::ST_RX_BUSY]  <= rx_run;
						s_axi_rdata[hfdu_pkg::ST_TX_BUSY]  <= !ld_ready;
					end
					hfdu_pkg::ADDR_RXDATA:  s_axi_rdata[7:0] <= rx_data_ff;
					hfdu_pkg::ADDR_TXCOUNT: s_axi_rdata[7:0] <= tx_left_ff;
					hfdu_pkg::ADDR_RXCOUNT: s_axi_rdata[7:0] <= rx_left_ff;
					hfdu_pkg::ADDR_TXDATA:  s_axi_rdata[7:0] <= tx_hold_ff;
					default: s_axi_rresp <= hfdu_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_idle_high;
		@(posedge aclk) disable iff (!aresetn)
		(u_tx.state_ff == hfdu_pkg::HFDU_IDLE) |-> txd;
	endproperty
	a_idle_high: assert property (p_idle_high) // [R19]
		else $error("line not high in idle");

	property p_ferr;
		@(posedge aclk) disable iff (!aresetn)
		rx_ferr |=> frame_err_ff;
	endproperty
	a_ferr: assert property (p_ferr) // [R11]
		else $error("framing error not flagged");

	property p_resync;
		@(posedge aclk) disable iff (!aresetn)
		rx_ferr |=> rx_state_ff == hfdu_pkg::HFDU_IDLE;
	endproperty
	a_resync: assert property (p_resync) // [R10]
		else $error("receiver did not resume hunting");

	property p_pause;
		@(posedge aclk) disable iff (!aresetn)
		(!rx_ie && !ctrl_ff[hfdu_pkg::CTRL_RX_ABORT]) |=>
			$stable(rx_cnt_ff) && $stable(rx_state_ff);
	endproperty
	a_pause: assert property (p_pause) // [R13]
		else $error("receiver moved while paused");

	property p_abort;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff[hfdu_pkg::CTRL_RX_ABORT] |=>
			rx_left_ff == 8'd0 && rx_state_ff == hfdu_pkg::HFDU_IDLE;
	endproperty
	a_abort: assert property (p_abort) // [R14]
		else $error("abort did not stop reception");

	property p_txdone;
		@(posedge aclk) disable iff (!aresetn)
		(tx_full_ff && ld_ready && tx_left_ff == 8'd1) |=>
			tx_done_ff && tx_left_ff == 8'd0;
	endproperty
	a_txdone: assert property (p_txdone) // [R15]
		else $error("transmit done not raised on last load");

	property p_start_bit;
		@(posedge aclk) disable iff (!aresetn)
		(tx_full_ff && ld_ready) |=> ##1 !serial_transmit_pin;
	endproperty
	a_start_bit: assert property (p_start_bit) // [R8]
		else $error("start bit not low");

	property p_rate_cap;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff[hfdu_pkg::CTRL_SLOW_CLK] |->
			rate.bit_len >= hfdu_pkg::bit_cycles(hfdu_pkg::RATE_SLOW_MAX);
	endproperty
	a_rate_cap: assert property (p_rate_cap) // [R7]
		else $error("rate above limit in slow clock mode");
endmodule
`default_nettype wire

// >>> sim/hfdu_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module hfdu_serial_peer #(
	parameter int BIT_LEN = 1736
) (
	input  wire logic aclk, // Clock
	input  wire logic txd,  // Line from the block
	output logic      rxd   // Line into the block
);
	logic [7:0] rx_q[$];
	logic       stop_q[$];
	int         start_q[$];
	int         cyc = 0;
	logic [7:0] b;

	always @(posedge aclk) cyc <= cyc + 1;

	// ----------------------------------------
	// Frame sender, stop level chosen by caller
	// ----------------------------------------
	initial rxd = 1'b1;
	task automatic send_byte(input logic [7:0] d, input logic stop_ok);
		@(posedge aclk);
		rxd <= 1'b0;
		repeat (BIT_LEN) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rxd <= d[i];
			repeat (BIT_LEN) @(posedge aclk);
		end
		rxd <= stop_ok;
		repeat (BIT_LEN) @(posedge aclk);
		rxd <= 1'b1;
		repeat (BIT_LEN) @(posedge aclk);
	endtask

	// Centre-sampling receiver of the block's transmit line
	initial forever begin
		@(negedge txd);
		start_q.push_back(cyc);
		repeat (BIT_LEN / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_LEN) @(posedge aclk);
			b[i] = txd;
		end
		repeat (BIT_LEN) @(posedge aclk);
		stop_q.push_back(txd);
		rx_q.push_back(b);
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int BL    = 200000000 / 115200;
	// Frames need about 92k cycles at the top rate
	localparam int LIMIT = 98000;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic rx_pin, tx_pin;
	logic [31:0] seed = 32'h48;
	logic [7:0] txb[4];
	logic [7:0] ra, rb, rc;
	int errors = 0, compares = 0, cyc = 0, gap = 0;

	hfdu_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_receive_pin(rx_pin),
		.serial_transmit_pin(tx_pin));
	hfdu_serial_peer #(.BIT_LEN(BL)) u_peer (.aclk(aclk), .txd(tx_pin),
		.rxd(rx_pin));

	// ----------------------------------------
	// Clock, timeout, checking
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic end_sim();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// Cycles from one start bit to the next, back to back
	function automatic int frame_len(input int stops);
		return (9 + stops) * BL;
	endfunction
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			end_sim();
		end
	end

	// ----------------------------------------
	// AXI4-Lite master
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
			output logic [1:0] resp);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		aw_t = 1'b0;
		w_t = 1'b0;
		do begin
			@(negedge aclk);
			aw_t = aw_t | (awvalid === 1'b1 && awready === 1'b1);
			w_t = w_t | (wvalid === 1'b1 && wready === 1'b1);
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (!(aw_t && w_t));
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			b_t = (bvalid === 1'b1);
			resp = bresp;
			@(posedge aclk);
		end while (!b_t);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
			output logic [1:0] resp);
		logic ar_t, r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ar_t = (arready === 1'b1);
			@(posedge aclk);
		end while (!ar_t);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			r_t = (rvalid === 1'b1);
			v = rdata;
			resp = rresp;
			@(posedge aclk);
		end while (!r_t);
		rready <= 1'b0;
	endtask
	task automatic poll(input int idx);
		do rd(hfdu_pkg::ADDR_STATUS, d, r);
		while (d[idx] !== 1'b1);
	endtask
	task automatic send_tx(input int base);
		for (int k = 0; k < 2; k++) begin
			poll(hfdu_pkg::ST_TX_READY);
			wr(hfdu_pkg::ADDR_TXDATA, {24'h0, txb[base+k]}, r);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		aresetn = 1'b0;
		for (int k = 0; k < 4; k++) txb[k] = 8'(xs());
		d = xs();
		{ra, rb, rc} = d[23:0];
		// Corner cases: all ones sent, all zeros into a bad stop bit
		txb[1] = 8'hff;
		rb = 8'h00;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(hfdu_pkg::ADDR_CTRL, d, r);
		chk(d, hfdu_pkg::CTRL_RESET);
		rd(8'h18, d, r);
		chk({30'h0, r}, {30'h0, hfdu_pkg::RESP_SLVERR});
		wr(hfdu_pkg::ADDR_RXDATA, 32'h0, r);
		chk({30'h0, r}, {30'h0, hfdu_pkg::RESP_SLVERR});
		// One-direction transmit, one stop bit
		wr(hfdu_pkg::ADDR_CTRL, 32'h29, r);
		wr(hfdu_pkg::ADDR_TXCOUNT, 32'h2, r);
		send_tx(0);
		poll(hfdu_pkg::ST_TX_DONE);
		chk_flag(u_peer.rx_q.size() < 2, 1'b1);
		while (u_peer.rx_q.size() < 2) @(posedge aclk);
		gap = u_peer.start_q[1] - u_peer.start_q[0];
		chk(gap, frame_len(1));
		// Full duplex, two stop bits, a bad stop bit received meanwhile
		wr(hfdu_pkg::ADDR_CTRL, 32'h39, r);
		wr(hfdu_pkg::ADDR_RXCOUNT, 32'h3, r);
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_RX_BUSY], 1'b1);
		wr(hfdu_pkg::ADDR_TXCOUNT, 32'h2, r);
		fork
			begin
				u_peer.send_byte(ra, 1'b1);
				u_peer.send_byte(rb, 1'b0);
			end
			begin
				send_tx(2);
				poll(hfdu_pkg::ST_RX_AVAIL);
				rd(hfdu_pkg::ADDR_RXDATA, d, r);
				chk({24'h0, d[7:0]}, {24'h0, ra});
			end
		join
		while (u_peer.rx_q.size() < 4) @(posedge aclk);
		gap = u_peer.start_q[3] - u_peer.start_q[2];
		chk_flag(gap >= frame_len(2), 1'b1);
		for (int k = 0; k < 4; k++) begin
			chk({24'h0, u_peer.rx_q[k]}, {24'h0, txb[k]});
			chk_flag(u_peer.stop_q[k], 1'b1);
		end
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_FRAME], 1'b1);
		rd(hfdu_pkg::ADDR_RXDATA, d, r);
		u_peer.send_byte(rc, 1'b1);
		poll(hfdu_pkg::ST_RX_AVAIL);
		rd(hfdu_pkg::ADDR_RXDATA, d, r);
		chk({24'h0, d[7:0]}, {24'h0, rc});
		wr(hfdu_pkg::ADDR_STATUS, 32'h1 << hfdu_pkg::ST_FRAME, r);
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_FRAME], 1'b0);
		// Abort an armed reception
		wr(hfdu_pkg::ADDR_RXCOUNT, 32'h5, r);
		wr(hfdu_pkg::ADDR_CTRL, 32'h79, r);
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_RX_DONE], 1'b1);
		chk_flag(d[hfdu_pkg::ST_RX_BUSY], 1'b0);
		// Pause with the receive enable low, then resume
		wr(hfdu_pkg::ADDR_CTRL, 32'h19, r);
		wr(hfdu_pkg::ADDR_RXCOUNT, 32'h1, r);
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_RX_BUSY], 1'b0);
		wr(hfdu_pkg::ADDR_CTRL, 32'h39, r);
		rd(hfdu_pkg::ADDR_STATUS, d, r);
		chk_flag(d[hfdu_pkg::ST_RX_BUSY], 1'b1);
		// Slow base clock mode with the top rate asked for
		wr(hfdu_pkg::ADDR_CTRL, 32'hb9, r);
		rd(hfdu_pkg::ADDR_CTRL, d, r);
		chk(d, 32'hb9);
		end_sim();
	end
endmodule
`default_nettype wire
